// ### verilog/ocsif_defs.svh
/*
 Offsets, field positions, reset values and timing counts of the command and event flag block.
 Assumes a 10 MHz controller clock.
*/
`ifndef OCSIF_DEFS_SVH
`define OCSIF_DEFS_SVH
// ==========================================
// Register offsets
`define OCSIF_CMD_OFS        8'h08
`define OCSIF_EVT_OFS        8'h0C
`define OCSIF_ENA_SET_OFS    8'h10
`define OCSIF_ENA_CLR_OFS    8'h14
// ==========================================
// Command register fields
`define OCSIF_CMD_RST_BIT    0
`define OCSIF_CMD_CLF_BIT    1
`define OCSIF_CMD_OCR_BIT    3
`define OCSIF_CMD_SOC_LO     16
// ==========================================
// Event and enable fields
`define OCSIF_EVT_SO_BIT     0
`define OCSIF_EVT_WDH_BIT    1
`define OCSIF_EVT_SF_BIT     2
`define OCSIF_EVT_RD_BIT     3
`define OCSIF_EVT_UE_BIT     4
`define OCSIF_EVT_FNO_BIT    5
`define OCSIF_EVT_ROOT_HUB_CHANGE_FLAG_BIT   6
`define OCSIF_EVT_OC_BIT     30
`define OCSIF_ENA_MIE_BIT    31
`define OCSIF_EVT_MASK       32'h4000007F
`define OCSIF_ENA_MASK       32'hC000007F
`define OCSIF_RESET_VALUE    32'h00000000
// ==========================================
// Timing
`define OCSIF_CLK_MHZ        10
`define OCSIF_RST_TIME_US    10
`define OCSIF_RST_CYCLES     (`OCSIF_RST_TIME_US * `OCSIF_CLK_MHZ)
`endif

// ### verilog/ocsif_pkg.sv
/*
 Types of the command and event flag block.
 Assumes ocsif_defs.svh is compiled alongside.
*/
package ocsif_pkg;
	// ==========================================
	// Register access request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} ocsif_req_t;

	// ==========================================
	// Hardware event pulses from the controller core
	typedef struct packed {
		logic rh_change;
		logic fn_msb_toggle;
		logic frame_ctr_stored;
		logic sys_error;
		logic resume_seen;
		logic sof_issued;
		logic done_head_stored;
		logic sched_overrun;
		logic ownership_done;
		logic ctl_list_start;
		logic ctl_td_found;
		logic ctl_pass_end;
	} ocsif_evt_t;

	typedef enum logic [1:0] {OCSIF_RUN, OCSIF_SOFT_RESET} ocsif_state_t;
endpackage : ocsif_pkg

// ### verilog/ocsif_top.sv
/*
 Command flags and event flag register with interrupt request gating.
 Assumes the core delivers one-cycle event pulses and register accesses are single-cycle.
*/
`timescale 1ns/1ns
`include "ocsif_defs.svh"

// How it works
// - Skip list when filled is zero; else clear
// - Found descriptor sets filled; stop when zero
// - Soft reset suspends, resets registers, blocks access
// - Soft reset finishes within ten microseconds, self-clears
// - Soft reset leaves root hub untouched
// - Events set flags; interrupt needs enable and master
// - Write one clears flag; hardware never clears
// - Ownership flag set on request; drives management interrupt
// - Root hub change sets its flag
// - Frame MSB toggle or stored frame sets overflow
// - System error sets flag and halts processing
// - Resume flag set on resume signaling onset
// - Start-of-frame flag set with SOF token unless halted
// - Done-head flag set; no rewrite until cleared
// - Overrun sets flag and bumps counter
// - Two-bit overrun counter wraps, always increments
// - Master enable gates every event interrupt
// - Ownership request cleared after changeover
module ocsif_top #(
	parameter int          RST_CYCLES = `OCSIF_RST_CYCLES,
	parameter logic        SMI_PIN    = 1'b1
) (
	input  wire logic               CLOCK_I,
	input  wire logic               RESET_N_I,
	input  wire ocsif_pkg::ocsif_req_t REQ_I,
	input  wire ocsif_pkg::ocsif_evt_t EVT_I,
	output logic [31:0]             RDATA_O,
	output logic                    READY_O,
	output logic                    IRQ_O,
	output logic                    SMI_O,
	output logic                    CTL_LIST_RUN_O,
	output logic                    HALT_O,
	output logic                    SUSPEND_O,
	output logic                    DONE_HEAD_ALLOW_O
);
	import ocsif_pkg::*;

	// ==========================================
	// State
	ocsif_state_t state,         next_state;
	logic [7:0]   rst_cnt,       next_rst_cnt;
	logic         control_list_filled,           next_clf;
	logic         ownership_change_request,           next_ocr;
	logic [1:0]   soc,           next_soc;
	logic [31:0]  evt,           next_evt;
	logic [31:0]  ena,           next_ena;
	logic         ctl_run,       next_ctl_run;
	logic         halt,          next_halt;
	logic         resume_prev,   next_resume_prev;
	logic [31:0]  rdata,         next_rdata;
	logic         irq,           next_irq;
	logic         smi,           next_smi;
	logic [31:0]  set_vec;
	logic         acc_ok;
	logic         wr_cmd,        wr_evt,        wr_ena_s, wr_ena_c;

	// ==========================================
	// Access decode
	always_comb begin
		acc_ok   = (state == OCSIF_RUN);
		wr_cmd   = acc_ok && REQ_I.wr && (REQ_I.addr == `OCSIF_CMD_OFS);
		wr_evt   = acc_ok && REQ_I.wr && (REQ_I.addr == `OCSIF_EVT_OFS);
		wr_ena_s = acc_ok && REQ_I.wr && (REQ_I.addr == `OCSIF_ENA_SET_OFS);
		wr_ena_c = acc_ok && REQ_I.wr && (REQ_I.addr == `OCSIF_ENA_CLR_OFS);
	end

	// ==========================================
	// Event set vector
	always_comb begin
		set_vec = 32'h00000000;
		set_vec[`OCSIF_EVT_OC_BIT]   = (ownership_change_request || (wr_cmd && REQ_I.wdata[`OCSIF_CMD_OCR_BIT])) && SMI_PIN;
		set_vec[`OCSIF_EVT_ROOT_HUB_CHANGE_FLAG_BIT] = EVT_I.rh_change;
		set_vec[`OCSIF_EVT_FNO_BIT]  = EVT_I.fn_msb_toggle || EVT_I.frame_ctr_stored;
		set_vec[`OCSIF_EVT_UE_BIT]   = EVT_I.sys_error;
		set_vec[`OCSIF_EVT_RD_BIT]   = EVT_I.resume_seen && !resume_prev;
		set_vec[`OCSIF_EVT_SF_BIT]   = EVT_I.sof_issued && !halt;
		set_vec[`OCSIF_EVT_WDH_BIT]  = EVT_I.done_head_stored;
		set_vec[`OCSIF_EVT_SO_BIT]   = EVT_I.sched_overrun;
	end

	// ==========================================
	// Next-state logic
	always_comb begin
		next_state       = state;
		next_rst_cnt     = rst_cnt;
		next_clf         = control_list_filled;
		next_ocr         = ownership_change_request;
		next_soc         = soc;
		next_evt         = evt;
		next_ena         = ena;
		next_ctl_run     = ctl_run;
		next_halt        = halt;
		next_resume_prev = EVT_I.resume_seen;
		next_rdata       = 32'h00000000;
		case (state)
			OCSIF_RUN: begin
				// Command register writes: ones set the control bits
				if (wr_cmd) begin
					if (REQ_I.wdata[`OCSIF_CMD_CLF_BIT]) next_clf = 1'b1;
					if (REQ_I.wdata[`OCSIF_CMD_OCR_BIT]) next_ocr = 1'b1;
				end
				// Control list walk
				if (EVT_I.ctl_list_start && !halt) begin
					next_ctl_run = control_list_filled;
					if (control_list_filled) next_clf = 1'b0;
				end
				if (EVT_I.ctl_td_found) next_clf = 1'b1;
				if (EVT_I.ctl_pass_end && !next_clf) next_ctl_run = 1'b0;
				if (EVT_I.ownership_done) next_ocr = 1'b0;
				// Overrun count wraps naturally
				if (EVT_I.sched_overrun) next_soc = soc + 2'h1;
				if (EVT_I.sys_error) begin
					next_halt    = 1'b1;
					next_ctl_run = 1'b0;
				end
				// Set wins over a simultaneous write-one clear
				if (wr_evt) next_evt = evt & ~(REQ_I.wdata & `OCSIF_EVT_MASK);
				next_evt = (next_evt | set_vec) & `OCSIF_EVT_MASK;
				if (wr_ena_s) next_ena = (ena | REQ_I.wdata) & `OCSIF_ENA_MASK;
				if (wr_ena_c) next_ena = ena & ~REQ_I.wdata;
				if (REQ_I.rd) begin
					case (REQ_I.addr)
						`OCSIF_CMD_OFS: begin
							next_rdata[`OCSIF_CMD_RST_BIT] = 1'b0;
							next_rdata[`OCSIF_CMD_CLF_BIT] = control_list_filled;
							next_rdata[`OCSIF_CMD_OCR_BIT] = ownership_change_request;
							next_rdata[`OCSIF_CMD_SOC_LO +: 2] = soc;
						end
						`OCSIF_EVT_OFS:     next_rdata = evt;
						`OCSIF_ENA_SET_OFS: next_rdata = ena;
						`OCSIF_ENA_CLR_OFS: next_rdata = ena;
						default:            next_rdata = 32'h00000000;
					endcase
				end
				// Soft reset request; root hub is outside this reset
				if (wr_cmd && REQ_I.wdata[`OCSIF_CMD_RST_BIT]) begin
					next_state   = OCSIF_SOFT_RESET;
					next_rst_cnt = 8'(RST_CYCLES - 1);
				end
			end
			OCSIF_SOFT_RESET: begin
				// Registers reset; root hub and port signalling untouched
				next_clf     = 1'b0;
				next_ocr     = 1'b0;
				next_soc     = 2'h0;
				next_evt     = `OCSIF_RESET_VALUE;
				next_ena     = `OCSIF_RESET_VALUE;
				next_ctl_run = 1'b0;
				next_halt    = 1'b0;
				if (rst_cnt == 8'h00) next_state = OCSIF_RUN;
				else next_rst_cnt = rst_cnt - 8'h01;
			end
			default: next_state = OCSIF_RUN;
		endcase
		// Interrupt gating
		next_irq = next_ena[`OCSIF_ENA_MIE_BIT] && |(next_evt & next_ena & 32'h0000007F);
		next_smi = next_ena[`OCSIF_ENA_MIE_BIT] && next_evt[`OCSIF_EVT_OC_BIT]
			&& next_ena[`OCSIF_EVT_OC_BIT] && SMI_PIN;
		if (next_state == OCSIF_SOFT_RESET) begin
			next_irq = 1'b0;
			next_smi = 1'b0;
		end
	end

	// ==========================================
	// Registers
	always_ff @(posedge CLOCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			state       <= OCSIF_RUN;
			rst_cnt     <= 8'h00;
			control_list_filled         <= 1'b0;
			ownership_change_request         <= 1'b0;
			soc         <= 2'h0;
			evt         <= `OCSIF_RESET_VALUE;
			ena         <= `OCSIF_RESET_VALUE;
			ctl_run     <= 1'b0;
			halt        <= 1'b0;
			resume_prev <= 1'b0;
			rdata       <= 32'h00000000;
			irq         <= 1'b0;
			smi         <= 1'b0;
		end else begin
			state       <= next_state;
			rst_cnt     <= next_rst_cnt;
			control_list_filled         <= next_clf;
			ownership_change_request         <= next_ocr;
			soc         <= next_soc;
			evt         <= next_evt;
			ena         <= next_ena;
			ctl_run     <= next_ctl_run;
			halt        <= next_halt;
			resume_prev <= next_resume_prev;
			rdata       <= next_rdata;
			irq         <= next_irq;
			smi         <= next_smi;
		end
	end

	// ==========================================
	// Outputs
	always_comb begin
		RDATA_O           = rdata;
		READY_O           = (state == OCSIF_RUN);
		IRQ_O             = irq;
		SMI_O             = smi;
		CTL_LIST_RUN_O    = ctl_run;
		HALT_O            = halt;
		SUSPEND_O         = (state == OCSIF_SOFT_RESET);
		DONE_HEAD_ALLOW_O = !evt[`OCSIF_EVT_WDH_BIT];
	end
endmodule : ocsif_top

// ### test/ocsif_monitor.sv
/* Checker of the command and event flag block, bound to ocsif_top.
 Assumes one-cycle event pulses and a single clock. */
`timescale 1ns/1ns
`include "ocsif_defs.svh"
module ocsif_monitor
	import ocsif_pkg::*;
#(
	parameter int RST_CYCLES = 100
) (
	input wire logic        CLOCK_I,
	input wire logic        RESET_N_I,
	input wire ocsif_req_t  REQ_I,
	input wire ocsif_evt_t  EVT_I,
	input wire logic [31:0] RDATA_O,
	input wire logic        READY_O,
	input wire logic        IRQ_O,
	input wire logic        SMI_O,
	input wire logic        HALT_O,
	input wire logic        SUSPEND_O,
	input wire logic        DONE_HEAD_ALLOW_O
);
	localparam int RMAX = RST_CYCLES + 2;
	wire wr_ok = REQ_I.wr && READY_O;
	default clocking @(posedge CLOCK_I); endclocking
	default disable iff (!RESET_N_I);
	// ==========================================
	// Properties
	chk_halt_set: assert property (EVT_I.sys_error && READY_O |=> HALT_O) else $error("halt missing");
	chk_halt_keep: assert property (HALT_O && !SUSPEND_O && !wr_ok |=> HALT_O) else $error("halt lost");
	chk_rst_done: assert property ($rose(SUSPEND_O) |-> ##[1:RMAX] !SUSPEND_O) else $error("reset long");
	chk_rst_block: assert property (SUSPEND_O |-> !READY_O && RDATA_O == 32'h0) else $error("access open");
	chk_rd_idle: assert property (!(REQ_I.rd && READY_O) |=> RDATA_O == 32'h0) else $error("stale data");
	chk_evt_resv: assert property (REQ_I.rd && READY_O && REQ_I.addr == `OCSIF_EVT_OFS
		|=> (RDATA_O & ~`OCSIF_EVT_MASK) == 32'h0) else $error("reserved set");
	chk_mie_gate: assert property (wr_ok && REQ_I.addr == `OCSIF_ENA_CLR_OFS && REQ_I.wdata[31]
		|=> !IRQ_O && !SMI_O) else $error("ungated irq");
	chk_irq_hold: assert property (IRQ_O && !wr_ok |=> IRQ_O) else $error("irq dropped");
	chk_dh_block: assert property (EVT_I.done_head_stored && READY_O |=> !DONE_HEAD_ALLOW_O)
		else $error("done head open");
endmodule : ocsif_monitor
bind ocsif_top ocsif_monitor #(.RST_CYCLES(RST_CYCLES)) ocsif_monitor_i (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
	.REQ_I(REQ_I), .EVT_I(EVT_I), .RDATA_O(RDATA_O), .READY_O(READY_O), .IRQ_O(IRQ_O), .SMI_O(SMI_O),
	.HALT_O(HALT_O), .SUSPEND_O(SUSPEND_O), .DONE_HEAD_ALLOW_O(DONE_HEAD_ALLOW_O));

// ### test/ocsif_host.sv
/* Host software model making register accesses.
 Assumes accesses are made only while ready is high. */
`timescale 1ns/1ns
module ocsif_host
	import ocsif_pkg::*;
(
	input  wire logic        clk,
	input  wire logic [31:0] rdata,
	output ocsif_req_t       req
);
	initial req = '0;
	// Held over one rising edge; lines scrambled at the next falling edge, answer then taken
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(negedge clk) req = '{w, !w, a, d};
		@(negedge clk) req = '{1'b0, 1'b0, ~a, ~d};
		q = rdata;
	endtask : acc
endmodule : ocsif_host

// ### test/tb_ocsif_top.sv
/* Self-checking bench of ocsif_top against an integer model.
 Assumes ocsif_host and ocsif_monitor are compiled alongside. */
`timescale 1ns/1ns
module tb_ocsif_top;
	import ocsif_pkg::*;
	logic CLOCK_I = 0, RESET_N_I = 0, irq, smi, run, halt, susp, ready, allow, control_list_filled = 0, ownership_change_request = 0, halt_m = 0;
	logic [11:0] evt = '0;
	logic [31:0] rdata, rd, flags = 0, ena = 0, seed = 59;
	logic [1:0] soc = 0;
	ocsif_req_t req;
	int error_cnt = 0, comparisons = 0, cyc = 0;
	always #50 CLOCK_I = ~CLOCK_I;
	ocsif_top #(.RST_CYCLES(4)) ocsif_top_i (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .REQ_I(req),
		.EVT_I(ocsif_evt_t'(evt)), .RDATA_O(rdata), .READY_O(ready), .IRQ_O(irq), .SMI_O(smi),
		.CTL_LIST_RUN_O(run), .HALT_O(halt), .SUSPEND_O(susp), .DONE_HEAD_ALLOW_O(allow));
	ocsif_host ocsif_host_i (.clk(CLOCK_I), .rdata(rdata), .req(req));
	always @(posedge CLOCK_I) if (++cyc > 3000) begin
		error_cnt++;
		final_report();
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic pins();
		cmp({28'h0, irq, smi, allow, halt}, {28'h0, ena[31] & |(flags[6:0] & ena[6:0]),
			ena[31] & ena[30] & flags[30], !flags[1], halt_m});
	endtask : pins
	task automatic rd_chk(input logic [7:0] a);
		ocsif_host_i.acc(1'b0, a, 32'h0, rd);
		cmp(rd, a == 8'h08 ? {14'h0, soc, 12'h0, ownership_change_request, 1'b0, control_list_filled, 1'b0} : a == 8'h0C ? flags : a[4] ? ena : 32'h0);
	endtask : rd_chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ocsif_host_i.acc(1'b1, a, d, rd);
		case (a)
			8'h08: begin control_list_filled |= d[1]; ownership_change_request |= d[3]; end
			8'h0C: flags &= ~d;
			8'h10: ena |= d & 32'hC000007F;
			default: ena &= ~d;
		endcase
		if (ownership_change_request) flags[30] = 1'b1;
		if (a == 8'h08 && d[0]) {flags, ena, control_list_filled, ownership_change_request, soc, halt_m} = '0;
	endtask : wr
	task automatic pulse(input int b);
		@(negedge CLOCK_I) evt = 12'(1 << b);
		@(negedge CLOCK_I) evt = '0;
		if (b >= 4 && !(b == 6 && halt_m)) flags[b < 10 ? b - 4 : b - 5] = 1'b1;
		if (b == 4) soc++;
		if (b == 8) halt_m = 1'b1;
		if (b == 3) ownership_change_request = 1'b0;
		if (b == 1) control_list_filled = 1'b1;
		if (b == 2 && !halt_m) control_list_filled = 1'b0;
	endtask : pulse
	task automatic final_report();
		$display("comparisons=%0d error_cnt=%0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	// ==========================================
	// Sequence
	initial begin
		repeat (2) @(posedge CLOCK_I);
		@(negedge CLOCK_I) RESET_N_I = 1;
		rd_chk(8'h08);
		rd_chk(8'h20);
		wr(8'h10, 32'hC000007F);
		for (int b = 4; b < 12; b++) begin
			pulse(b);
			pins();
		end
		rd_chk(8'h0C);
		repeat (4) pulse(4);
		rd_chk(8'h08);
		$display("events done");
		wr(8'h0C, rnd());
		rd_chk(8'h0C);
		wr(8'h0C, 32'h7F); // low seven flags cleared before a SOF pulse while halted
		pulse(6);
		rd_chk(8'h0C);
		wr(8'h08, 32'h8);
		pins();
		wr(8'h14, 32'h80000000);
		pins();
		pulse(3);
		rd_chk(8'h08);
		wr(8'h0C, 32'h40000000);
		rd_chk(8'h14);
		wr(8'h08, 32'h1);
		repeat (20) if (!ready) @(negedge CLOCK_I);
		pins();
		$display("ownership done");
		wr(8'h08, 32'h2);
		pulse(2);
		cmp({31'h0, run}, 32'h1);
		pulse(1);
		rd_chk(8'h08);
		pulse(2);
		pulse(0);
		cmp({31'h0, run}, 32'h0);
		pulse(2);
		cmp({31'h0, run}, 32'h0);
		wr(8'h08, 32'h1);
		cmp({30'h0, susp, ready}, 32'h2);
		repeat (20) if (!ready) @(negedge CLOCK_I);
		rd_chk(8'h0C);
		pins();
		$display("soft reset done");
		final_report();
	end
endmodule : tb_ocsif_top
